// ---- logic/ove_pkg.sv ----
// constants shared by both ends of the octal volatile enable descriptor link
//------------------------------------------------------------
//------------------------------------------------------------
package ove_pkg;
    // descriptor field positions
    localparam int DESC_AVAIL = 31;
    localparam int DESC_INV = 30;
    localparam int DESC_RSVD = 29;
    localparam int DESC_ADDRD = 28;
    localparam int DESC_BYTE1 = 27;
    localparam int DESC_POS_LSB = 24;
    localparam int DESC_MID_LSB = 16;
    localparam int DESC_MODE_LSB = 20;
    localparam int DESC_DUMMY_LSB = 16;
    localparam int DESC_RDOP_LSB = 8;
    localparam int DESC_WROP_LSB = 0;
    // memory-side reset value of the config register
    localparam logic [7:0] CFG_RST = 8'h00;
    // command that streams out the descriptor word
    localparam logic [7:0] OP_RDESC = 8'h5a;
    // serial clock half period in system clocks
    localparam int LINK_HALF = 8;
    // last bit index of each frame kind
    localparam logic [5:0] LAST_DESC = 6'h27;
    localparam logic [5:0] LAST_ADDR = 6'h2f;
    localparam logic [5:0] LAST_DIRECT = 6'h0f;
    // host register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DESC = 8'h08;
    localparam logic [7:0] REG_VALUE = 8'h0c;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ABSENT = 2;
    localparam int ST_NOOP = 3;
    localparam int ST_OCTAL = 4;
endpackage : ove_pkg

// ---- logic/ove_link_if.sv ----
// serial link between the host controller and the memory end
`timescale 1ns/1ps
interface ove_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    modport host (output sck, output cs_n, output mosi, input miso);
    modport mem (input sck, input cs_n, input mosi, output miso);
endinterface : ove_link_if

// ---- logic/ove_mem.sv ----
// memory end: publishes the descriptor and holds the volatile config byte
`timescale 1ns/1ps
module ove_mem #(
    parameter logic P_AVAIL = 1'b1,
    parameter logic P_INV = 1'b0,
    parameter logic P_ADDRD = 1'b1,
    parameter logic P_BYTE1 = 1'b0,
    parameter logic [2:0] P_BITPOS = 3'h3,
    parameter logic [7:0] P_LADDR = 8'h02,
    parameter logic [3:0] P_MODES = 4'hf,
    parameter logic [3:0] P_DUMMY = 4'h8,
    parameter logic [7:0] P_RD_OP = 8'h65,
    parameter logic [7:0] P_WR_OP = 8'h71
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    ove_link_if.mem link,
    output logic o_octal_on,
    output logic [7:0] o_cfg
);
    typedef enum logic [4:0] {
        M_CMD = 5'b00001,
        M_ADDR = 5'b00010,
        M_DOUT = 5'b00100,
        M_WDAT = 5'b01000,
        M_IGN = 5'b10000
    } ove_mst_t;

    //------------------------------------------------------------
    // descriptor word
    //------------------------------------------------------------
    wire logic [7:0] mid = P_ADDRD ? P_LADDR : {P_MODES, P_DUMMY};
    // reserved bit forced low so later meanings are not faked
    wire logic [31:0] desc = {P_AVAIL, P_INV, 1'b0, P_ADDRD, P_BYTE1, P_BITPOS, mid, P_RD_OP, P_WR_OP};

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic [2:0] sck_r;
    logic [1:0] cs_r;
    logic [1:0] mosi_r;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_r <= 3'h0;
            cs_r <= 2'h3;
            mosi_r <= 2'h0;
        end
        else
        begin
            sck_r <= {sck_r[1:0], link.sck};
            cs_r <= {cs_r[0], link.cs_n};
            mosi_r <= {mosi_r[0], link.mosi};
        end
    end

    //------------------------------------------------------------
    // byte engine
    //------------------------------------------------------------
    ove_mst_t st_q;
    logic [2:0] bit_q;
    logic [6:0] sh_q;
    logic [23:0] addr_q;
    logic [1:0] ab_q;
    logic wr_q;
    logic match_q;
    logic [31:0] tx_q;
    logic miso_q;
    logic [7:0] cfg_q;
    logic octal_q;

    wire logic rise = sck_r[1] & ~sck_r[2] & ~cs_r[1];
    wire logic fall = ~sck_r[1] & sck_r[2] & ~cs_r[1];
    wire logic [7:0] rxb = {sh_q, mosi_r[1]};
    wire logic byte_done = rise & (bit_q == 3'h7);
    // a zero opcode never decodes, it marks the command as absent
    wire logic rd_hit = P_AVAIL & (P_RD_OP != 8'h00) & (rxb == P_RD_OP);
    wire logic wr_hit = P_AVAIL & (P_WR_OP != 8'h00) & (rxb == P_WR_OP);
    wire logic [31:0] afull = {addr_q, rxb};
    wire logic [7:0] asel = P_BYTE1 ? afull[15:8] : afull[7:0];
    wire logic amatch = asel == P_LADDR;
    wire logic [31:0] cfg_word = {cfg_q, 24'h000000};

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= M_CMD;
            bit_q <= 3'h0;
            sh_q <= 7'h00;
            addr_q <= 24'h000000;
            ab_q <= 2'h0;
            wr_q <= 1'b0;
            match_q <= 1'b0;
            tx_q <= 32'h00000000;
            miso_q <= 1'b0;
        end
        else if (cs_r[1])
        begin
            st_q <= M_CMD;
            bit_q <= 3'h0;
            tx_q <= 32'h00000000;
            miso_q <= 1'b0;
        end
        else if (fall)
        begin
            miso_q <= tx_q[31];
            tx_q <= {tx_q[30:0], 1'b0};
        end
        else if (rise)
        begin
            bit_q <= bit_q + 3'h1;
            sh_q <= rxb[6:0];
            if (bit_q == 3'h7)
            begin
                case (st_q)
                    M_CMD:
                    begin
                        ab_q <= 2'h0;
                        wr_q <= wr_hit;
                        match_q <= 1'b1;
                        if (rxb == ove_pkg::OP_RDESC)
                        begin
                            tx_q <= desc;
                            st_q <= M_DOUT;
                        end
                        else if (rd_hit && P_ADDRD)
                            st_q <= M_ADDR;
                        else if (rd_hit)
                        begin
                            tx_q <= cfg_word;
                            st_q <= M_DOUT;
                        end
                        else if (wr_hit)
                            st_q <= P_ADDRD ? M_ADDR : M_WDAT;
                        else
                            st_q <= M_IGN;
                    end
                    M_ADDR:
                    begin
                        addr_q <= afull[23:0];
                        ab_q <= ab_q + 2'h1;
                        if (ab_q == 2'h3 && wr_q)
                        begin
                            match_q <= amatch;
                            st_q <= M_WDAT;
                        end
                        else if (ab_q == 2'h3)
                        begin
                            tx_q <= amatch ? cfg_word : 32'h00000000;
                            st_q <= M_DOUT;
                        end
                    end
                    M_WDAT: st_q <= M_IGN;
                    M_DOUT: st_q <= M_DOUT;
                    M_IGN: st_q <= M_IGN;
                    default: st_q <= M_IGN;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // config byte and octal state
    //------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg_q <= ove_pkg::CFG_RST;
            octal_q <= 1'b0;
        end
        else
        begin
            if (byte_done && st_q == M_WDAT && match_q)
                cfg_q <= rxb;
            octal_q <= P_AVAIL & (cfg_q[P_BITPOS] ^ P_INV);
        end
    end

    assign link.miso = miso_q;
    assign o_cfg = cfg_q;
    assign o_octal_on = octal_q;
endmodule : ove_mem

// ---- logic/ove_host.sv ----
// host controller: reads the descriptor and switches the memory to octal mode
`timescale 1ns/1ps
module ove_host #(
    parameter int HALF = ove_pkg::LINK_HALF
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    ove_link_if.host link,
    output logic o_octal_on
);
    typedef enum logic [6:0] {
        H_IDLE = 7'b0000001,
        H_DESC = 7'b0000010,
        H_CHK = 7'b0000100,
        H_RD = 7'b0001000,
        H_MOD = 7'b0010000,
        H_WR = 7'b0100000,
        H_FIN = 7'b1000000
    } ove_hst_t;

    localparam int DW = $clog2(HALF);

    //------------------------------------------------------------
    // serial clock divider
    //------------------------------------------------------------
    logic [DW-1:0] div_q;
    wire logic tick = div_q == DW'(HALF - 1);
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            div_q <= '0;
        else
            div_q <= tick ? '0 : div_q + DW'(1);
    end

    //------------------------------------------------------------
    // state and link registers
    //------------------------------------------------------------
    ove_hst_t st_q;
    logic sck_q;
    logic cs_n_q;
    logic [47:0] frame_q;
    logic [5:0] bit_q;
    logic [5:0] last_q;
    logic [31:0] rx_q;
    logic [1:0] miso_r;
    logic [31:0] desc_q;
    logic [7:0] reg_q;
    logic done_q;
    logic absent_q;
    logic noop_q;
    logic octal_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    //------------------------------------------------------------
    // descriptor decode
    //------------------------------------------------------------
    wire logic d_avail = desc_q[ove_pkg::DESC_AVAIL];
    wire logic d_inv = desc_q[ove_pkg::DESC_INV];
    wire logic d_acc = desc_q[ove_pkg::DESC_ADDRD];
    wire logic d_byte1 = desc_q[ove_pkg::DESC_BYTE1];
    wire logic [2:0] d_pos = desc_q[ove_pkg::DESC_POS_LSB +: 3];
    wire logic [7:0] d_mid = desc_q[ove_pkg::DESC_MID_LSB +: 8];
    wire logic [7:0] d_rdop = desc_q[ove_pkg::DESC_RDOP_LSB +: 8];
    wire logic [7:0] d_wrop = desc_q[ove_pkg::DESC_WROP_LSB +: 8];
    // mode flags and dummy count are only reported; the host talks
    // single-line, which needs no dummies, so a clear flag never
    // stops it
    wire logic [3:0] d_modes = desc_q[ove_pkg::DESC_MODE_LSB +: 4];
    wire logic [3:0] d_dummy = desc_q[ove_pkg::DESC_DUMMY_LSB +: 4];
    // bit 29 is left undecoded so a later meaning cannot upset the host

    // local address placement inside the 32-bit address
    wire logic [31:0] addr32 = d_byte1 ? {16'h0000, d_mid, 8'h00} : {24'h000000, d_mid};
    wire logic [47:0] frame_desc = {ove_pkg::OP_RDESC, 40'h0000000000};
    wire logic [47:0] frame_rd = d_acc ? {d_rdop, addr32, 8'h00} : {d_rdop, 40'h0000000000};
    // set or clear depending on the published sense, keep other bits
    wire logic en_val = ~d_inv;
    wire logic [7:0] pos_mask = 8'h01 << d_pos;
    wire logic [7:0] new_byte = (reg_q & ~pos_mask) | (en_val ? pos_mask : 8'h00);
    wire logic [47:0] frame_wr = d_acc ? {d_wrop, addr32, new_byte} : {d_wrop, new_byte, 32'h00000000};
    wire logic [5:0] last_rw = d_acc ? ove_pkg::LAST_ADDR : ove_pkg::LAST_DIRECT;
    wire logic no_op = (d_rdop == 8'h00) | (d_wrop == 8'h00);

    wire logic xfer = (st_q == H_DESC) | (st_q == H_RD) | (st_q == H_WR);
    wire logic fdone = xfer & tick & sck_q & (bit_q == last_q);

    //------------------------------------------------------------
    // register bus decode
    //------------------------------------------------------------
    wire logic apb_acc = i_psel & i_penable & ~pready_q;
    wire logic apb_fin = i_psel & i_penable & pready_q;
    wire logic hit_ctrl = i_paddr == ove_pkg::REG_CTRL;
    wire logic hit_stat = i_paddr == ove_pkg::REG_STATUS;
    wire logic hit_desc = i_paddr == ove_pkg::REG_DESC;
    wire logic hit_val = i_paddr == ove_pkg::REG_VALUE;
    wire logic mapped = hit_ctrl | hit_stat | hit_desc | hit_val;
    // starts issued while busy are dropped
    wire logic start = apb_fin & i_pwrite & hit_ctrl & i_pwdata[0] & (st_q == H_IDLE);
    wire logic [31:0] status = {5'h00, d_pos, d_modes, d_dummy, 11'h000,
        octal_q, noop_q, absent_q, done_q, ~(st_q == H_IDLE)};
    wire logic [31:0] rd_mux = hit_stat ? status :
                               hit_desc ? desc_q :
                               hit_val ? {24'h000000, reg_q} : 32'h00000000;

    //------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= H_IDLE;
            cs_n_q <= 1'b1;
            frame_q <= 48'h000000000000;
            last_q <= 6'h00;
            desc_q <= 32'h00000000;
            reg_q <= 8'h00;
            done_q <= 1'b0;
            absent_q <= 1'b0;
            noop_q <= 1'b0;
            octal_q <= 1'b0;
        end
        else
        begin
            if (xfer && tick && sck_q)
                frame_q <= {frame_q[46:0], 1'b0};
            case (st_q)
                H_IDLE:
                    if (start)
                    begin
                        done_q <= 1'b0;
                        absent_q <= 1'b0;
                        noop_q <= 1'b0;
                        frame_q <= frame_desc;
                        last_q <= ove_pkg::LAST_DESC;
                        cs_n_q <= 1'b0;
                        st_q <= H_DESC;
                    end
                H_DESC:
                    if (fdone)
                    begin
                        desc_q <= rx_q;
                        cs_n_q <= 1'b1;
                        st_q <= H_CHK;
                    end
                H_CHK:
                    if (tick)
                    begin
                        if (!d_avail)
                        begin
                            absent_q <= 1'b1;
                            st_q <= H_FIN;
                        end
                        else if (no_op)
                        begin
                            noop_q <= 1'b1;
                            st_q <= H_FIN;
                        end
                        else
                        begin
                            frame_q <= frame_rd;
                            last_q <= last_rw;
                            cs_n_q <= 1'b0;
                            st_q <= H_RD;
                        end
                    end
                H_RD:
                    if (fdone)
                    begin
                        reg_q <= rx_q[7:0];
                        cs_n_q <= 1'b1;
                        st_q <= H_MOD;
                    end
                H_MOD:
                    if (tick)
                    begin
                        frame_q <= frame_wr;
                        last_q <= last_rw;
                        cs_n_q <= 1'b0;
                        st_q <= H_WR;
                    end
                H_WR:
                    if (fdone)
                    begin
                        reg_q <= new_byte;
                        octal_q <= 1'b1;
                        cs_n_q <= 1'b1;
                        st_q <= H_FIN;
                    end
                H_FIN:
                begin
                    done_q <= 1'b1;
                    st_q <= H_IDLE;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // bit engine: drive on the falling half, sample on the rising
    //------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_q <= 1'b0;
            bit_q <= 6'h00;
            rx_q <= 32'h00000000;
            miso_r <= 2'h0;
        end
        else
        begin
            miso_r <= {miso_r[0], link.miso};
            if (!xfer)
            begin
                sck_q <= 1'b0;
                bit_q <= 6'h00;
            end
            else if (tick && !sck_q)
            begin
                sck_q <= 1'b1;
                rx_q <= {rx_q[30:0], miso_r[1]};
            end
            else if (tick)
            begin
                sck_q <= 1'b0;
                bit_q <= bit_q + 6'h01;
            end
        end
    end

    //------------------------------------------------------------
    // register bus slave
    //------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= apb_acc;
            if (apb_acc)
            begin
                pslverr_q <= ~mapped;
                prdata_q <= i_pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    assign link.sck = sck_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = frame_q[47];
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_octal_on = octal_q;
endmodule : ove_host

// ---- dv/ove_link_properties.sv ----
// protocol checker for the serial link between host and memory ends
`timescale 1ns/1ps
module ove_link_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic i_miso
);
    // ----
    // frame bookkeeping
    // ----
    logic sck_q;
    logic cs_q;
    logic [7:0] nrise_q;
    logic [1:0] nframe_q;
    wire rise = i_sck & ~sck_q & ~i_cs_n;
    wire frame_end = i_cs_n & ~cs_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            nrise_q <= 8'h00;
            nframe_q <= 2'h0;
        end
        else
        begin
            sck_q <= i_sck;
            cs_q <= i_cs_n;
            nrise_q <= i_cs_n ? 8'h00 : nrise_q + {7'h00, rise};
            if (frame_end && nframe_q != 2'h3)
                nframe_q <= nframe_q + 2'h1;
        end
    end
    // ----
    // properties
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_sck_idle_low: assert property (i_cs_n |-> !i_sck)
        else $error("serial clock high outside a frame");
    chk_sck_high_half: assert property ($rose(i_sck) |-> i_sck [*8] ##1 !i_sck)
        else $error("serial clock high phase length wrong");
    chk_sck_low_half: assert property ($fell(i_sck) && !i_cs_n |-> !i_sck [*8])
        else $error("serial clock low phase too short");
    chk_mosi_hold: assert property (i_sck && $past(i_sck) |-> $stable(i_mosi))
        else $error("host data moved while clock high");
    chk_miso_hold: assert property (i_sck && $past(i_sck) |-> $stable(i_miso))
        else $error("memory data moved while clock high");
    chk_frame_bit_count: assert property ($rose(i_cs_n) |-> nrise_q inside {8'h10, 8'h28, 8'h30})
        else $error("frame length is not a legal count");
    chk_first_frame_desc: assert property ($rose(i_cs_n) && nframe_q == 2'h0 |-> nrise_q == 8'h28)
        else $error("first frame is not a descriptor read");
    chk_frame_gap: assert property ($rose(i_cs_n) |-> i_cs_n [*6])
        else $error("frames too close together");
    chk_frame_start: assert property ($fell(i_cs_n) |-> !i_sck ##[1:16] i_sck)
        else $error("no clock after frame select");
    cover property ($rose(i_cs_n) && nrise_q == 8'h28);
    cover property ($rose(i_cs_n) && nrise_q == 8'h30);
    cover property (frame_end && nframe_q == 2'h2);
endmodule : ove_link_chk

// ---- dv/tb.sv ----
// bench: an addressed pair, a direct-command pair and a pair without the feature, driven over apb
`timescale 1ns/1ps
module tb;
    logic i_clk;
    logic i_rst_n;
    logic psel_a;
    logic psel_b;
    logic psel_c;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic rdy_a;
    logic rdy_b;
    logic err_a;
    logic err_b;
    wire [1:0] oct_a;
    wire [1:0] oct_b;
    wire [1:0] oct_c;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [31:0] rd_c;
    logic rdy_c;
    logic err_c;
    logic [7:0] cfg_c;
    logic [47:0] mo_q;
    logic [47:0] mi_q;
    int n_mismatch = 0;
    int checks_done = 0;
    int nfr = 0;
    logic [31:0] exp_desc [2] = '{32'h93026571, 32'hc5a76571};
    logic [31:0] exp_stat [2] = '{32'h03020012, 32'h05a70012};
    logic [7:0] exp_cfg [2] = '{8'h08, 8'h00};
    ove_link_if link_a ();
    ove_link_if link_b ();
    ove_link_if link_c ();
    ove_host ove_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel_a), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(rd_a), .o_pready(rdy_a),
        .o_pslverr(err_a), .link(link_a), .o_octal_on(oct_a[1]));
    ove_mem ove_mem_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_a), .o_octal_on(oct_a[0]), .o_cfg(cfg_a));
    // inverted polarity with direct commands, so the host must clear the bit
    ove_host ove_host_b_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel_b), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(rd_b), .o_pready(rdy_b),
        .o_pslverr(err_b), .link(link_b), .o_octal_on(oct_b[1]));
    ove_mem #(.P_INV(1'b1), .P_ADDRD(1'b0), .P_BITPOS(3'h5), .P_MODES(4'ha), .P_DUMMY(4'h7)) ove_mem_b_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_b), .o_octal_on(oct_b[0]), .o_cfg(cfg_b));
    // a memory without the feature: the host must stop after the descriptor
    ove_host ove_host_c_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel_c), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(rd_c), .o_pready(rdy_c),
        .o_pslverr(err_c), .link(link_c), .o_octal_on(oct_c[1]));
    ove_mem #(.P_AVAIL(1'b0)) ove_mem_c_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_c),
        .o_octal_on(oct_c[0]), .o_cfg(cfg_c));
    ove_link_chk ove_link_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(link_a.sck), .i_cs_n(link_a.cs_n),
        .i_mosi(link_a.mosi), .i_miso(link_a.miso));
    always #2.5 i_clk = ~i_clk;
    // ----
    // tasks
    // ----
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input int b, input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel_a <= (b == 0);
        psel_b <= (b == 1);
        psel_c <= (b == 2);
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge i_clk);
            k++;
        end
        while ((b == 2 ? rdy_c : b == 1 ? rdy_b : rdy_a) !== 1'b1 && k < 50);
        r = b == 2 ? rd_c : b == 1 ? rd_b : rd_a;
        e = b == 2 ? err_c : b == 1 ? err_b : err_a;
        psel_a <= 1'b0;
        psel_b <= 1'b0;
        psel_c <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
        begin
            n_mismatch++;
            $display("BAD apb ready expected 1 seen 0");
            report_and_stop();
        end
        else
            @(posedge i_clk);
    endtask : apb
    // ----
    // link monitor and main sequence
    // ----
    always @(posedge link_a.sck)
        if (!link_a.cs_n)
        begin
            mo_q = {mo_q[46:0], link_a.mosi};
            mi_q = {mi_q[46:0], link_a.miso};
        end
    always @(posedge link_a.cs_n)
        if (i_rst_n)
        begin
            nfr++;
            if (nfr == 1)
            begin
                chk("desc opcode", 32'(mo_q[39:32]), 32'(ove_pkg::OP_RDESC));
                chk("desc on wire", mi_q[31:0], exp_desc[0]);
            end
            else
            begin
                chk("opcode", 32'(mo_q[47:40]), nfr == 2 ? 32'h65 : 32'h71);
                chk("reg address", 32'(mo_q[15:8]), 32'h02);
                chk("data byte", 32'(nfr == 2 ? mi_q[7:0] : mo_q[7:0]), nfr == 2 ? 32'h0 : 32'h08);
            end
            mo_q = 48'h0;
            mi_q = 48'h0;
        end
    initial
    begin
        logic [31:0] r;
        logic e;
        int k;
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        psel_a = 1'b0;
        psel_b = 1'b0;
        psel_c = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        for (int b = 0; b < 2; b++)
        begin
            apb(b[0], 1'b0, ove_pkg::REG_STATUS, 32'h0, r, e);
            chk("status at reset", r, 32'h0);
            chk("status error", 32'(e), 32'h0);
            // inverted sense with a cleared reset byte means the memory starts enabled
            chk("octal before start", 32'(b ? oct_b : oct_a), b ? 32'h1 : 32'h0);
            apb(b[0], 1'b1, ove_pkg::REG_CTRL, 32'h1, r, e);
            // a second start while busy must be ignored
            apb(b[0], 1'b1, ove_pkg::REG_CTRL, 32'h1, r, e);
            apb(b[0], 1'b0, ove_pkg::REG_STATUS, 32'h0, r, e);
            chk("busy", 32'(r[ove_pkg::ST_BUSY]), 32'h1);
            k = 0;
            do
            begin
                apb(b[0], 1'b0, ove_pkg::REG_STATUS, 32'h0, r, e);
                k++;
            end
            while (r[ove_pkg::ST_DONE] !== 1'b1 && k < 2000);
            chk("done in time", 32'(k < 2000), 32'h1);
            if (k >= 2000)
                report_and_stop();
            apb(b[0], 1'b0, ove_pkg::REG_DESC, 32'h0, r, e);
            chk("desc", r, exp_desc[b]);
            chk("dummy field", 32'(r[ove_pkg::DESC_DUMMY_LSB +: 4]), b ? 32'h7 : 32'h2);
            apb(b[0], 1'b0, ove_pkg::REG_STATUS, 32'h0, r, e);
            chk("status", r, exp_stat[b]);
            apb(b[0], 1'b0, ove_pkg::REG_VALUE, 32'h0, r, e);
            chk("value", r, 32'(exp_cfg[b]));
            chk("octal and cfg", 32'(b ? {oct_b, cfg_b} : {oct_a, cfg_a}), 32'({2'b11, exp_cfg[b]}));
        end
        // bit 31 clear: absent flag, and no read or write of the config byte
        apb(2, 1'b1, ove_pkg::REG_CTRL, 32'h1, r, e);
        k = 0;
        do
        begin
            apb(2, 1'b0, ove_pkg::REG_STATUS, 32'h0, r, e);
            k++;
        end
        while (r[ove_pkg::ST_DONE] !== 1'b1 && k < 2000);
        chk("absent done in time", 32'(k < 2000), 32'h1);
        if (k >= 2000)
            report_and_stop();
        chk("absent status", r, 32'h03020006);
        apb(2, 1'b0, ove_pkg::REG_DESC, 32'h0, r, e);
        chk("absent desc", r, 32'h13026571);
        chk("absent octal and cfg", 32'({oct_c, cfg_c}), 32'h0);
        apb(1'b0, 1'b0, 8'h10, 32'h0, r, e);
        chk("unmapped data", r, 32'h0);
        chk("unmapped error", 32'(e), 32'h1);
        apb(1'b0, 1'b1, ove_pkg::REG_DESC, 32'hffffffff, r, e);
        apb(1'b0, 1'b0, ove_pkg::REG_DESC, 32'h0, r, e);
        chk("desc read only", r, exp_desc[0]);
        apb(1'b0, 1'b0, ove_pkg::REG_CTRL, 32'h0, r, e);
        chk("ctrl reads zero", r, 32'h0);
        chk("frames on link", 32'(nfr), 32'h3);
        report_and_stop();
    end
endmodule : tb
